// *** logic/ips_map.svh ***
// Purpose: offsets, field positions, reset values and counts of the
//          interrupt pin signalling block
// Assumes: 32-bit classic wishbone, byte addresses, one word per register
// Notes:   included by the top-level design file, the checker and the bench
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH

// register byte offsets
`define IPS_OFS_POLARITY  8'h00
`define IPS_OFS_ENABLE    8'h04
`define IPS_OFS_PENDING   8'h08
`define IPS_OFS_SERVICE   8'h0c
`define IPS_OFS_PWRDN     8'h10
`define IPS_OFS_EVT_STAT  8'h14
`define IPS_OFS_EVT_MASK  8'h18

// reset values
`define IPS_RST_POLARITY  4'h0
`define IPS_RST_ENABLE    16'h0000
`define IPS_RST_PWRDN     2'h0
`define IPS_RST_EVT_MASK  6'h00

// service-table slots
`define IPS_SLOT_NMI      4'h1
`define IPS_SLOT_EXT0     4
`define IPS_SLOT_INT0     8
`define IPS_NUM_SLOTS     16

// enable register: bit 0 is the global enable for maskable sources
`define IPS_EN_GLOBAL     0

// service register fields
`define IPS_SVC_BUSY      4

// event status bits
`define IPS_EVT_NMI       0
`define IPS_EVT_EXT0      1
`define IPS_EVT_TAKEN     5
`define IPS_EVT_W         6

// acknowledge pulse length in clock cycles
`define IPS_ACK_CYCLES    3'd2

`endif

// *** logic/ips_pkg.sv ***
// Purpose: types of the interrupt pin signalling block
// Assumes: nothing beyond the map header
// Notes:   service sequencer states are one-hot
package ips_pkg;

  typedef enum logic [2:0] {
    IPS_IDLE = 3'b001,
    IPS_ACK  = 3'b010,
    IPS_BUSY = 3'b100
  } ips_state_t;

  typedef logic [1:0] ips_pd_mode_t;
  typedef logic [3:0] ips_slot_t;

endpackage : ips_pkg

// *** logic/ips_edge_det.sv ***
// Purpose: per-line edge detector with selectable active edge
// Assumes: inputs synchronous to clk
// Notes:   first cycle after reset only captures, so a line that is
//          already high cannot fake an edge
`timescale 1ns/10ps

module ips_edge_det #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] line,
  input  wire logic [W-1:0] falling,
  output logic      [W-1:0] edge_hit
);

  logic [W-1:0] prev_q;
  logic         armed_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= line;
      armed_q <= 1'b1;
    end
  end

  // polarity bit low picks the rising edge, high the falling edge
  always_comb begin
    edge_hit = '0;
    if (armed_q) begin
      edge_hit = (~falling & line & ~prev_q) |
                 (falling & ~line & prev_q);
    end
  end

endmodule : ips_edge_det

// *** logic/ips_prio_enc.sv ***
// Purpose: picks the lowest-numbered pending slot
// Assumes: bit n of req stands for service-table slot n
// Notes:   lower slot means higher priority
`timescale 1ns/10ps

module ips_prio_enc
  import ips_pkg::*;
(
  input  wire logic [15:0] req,
  output logic             found,
  output ips_slot_t        slot
);

  always_comb begin
    found = 1'b0;
    slot  = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        slot  = 4'(i);
      end
    end
  end

endmodule : ips_prio_enc

// *** logic/ips_top.sv ***
// Purpose: interrupt pin signalling: edge capture, acknowledge and number
//          outputs, power-down status, wishbone registers
// Assumes: all inputs synchronous to clk; single 125 MHz clock
// Notes:   slot 1 is the nonmaskable request, slots 4..7 the external
//          lines, slots 8..15 the internal requests
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps

`include "ips_map.svh"

module ips_top
  import ips_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interrupt pins
  input  wire logic        nmi_in,
  input  wire logic        ext_irq_in_0,
  input  wire logic        ext_irq_in_1,
  input  wire logic        ext_irq_in_2,
  input  wire logic        ext_irq_in_3,
  input  wire logic [7:0]  int_req_in,
  output logic             irq_ack_out,
  output logic             active_irq_number_0,
  output logic             active_irq_number_1,
  output logic             active_irq_number_2,
  output logic             active_irq_number_3,
  output logic             powerdown_flag,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge for the two low lanes
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [3:0]  sel
  );
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : lane_merge

  function automatic logic pd_deep(input ips_pd_mode_t mode);
    return (mode == 2'h2) || (mode == 2'h3);
  endfunction : pd_deep

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        bus_req;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] wdat;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en   = bus_req & wb_we_i;
  assign rd_en   = bus_req & ~wb_we_i;
  assign wdat    = wb_dat_i[15:0];

  logic wr_pol;
  logic wr_en_reg;
  logic wr_svc;
  logic wr_pd;
  logic wr_stat;
  logic wr_mask;

  assign wr_pol    = wr_en & (wb_adr_i == `IPS_OFS_POLARITY);
  assign wr_en_reg = wr_en & (wb_adr_i == `IPS_OFS_ENABLE);
  assign wr_svc    = wr_en & (wb_adr_i == `IPS_OFS_SERVICE) & wb_sel_i[0];
  assign wr_pd     = wr_en & (wb_adr_i == `IPS_OFS_PWRDN);
  assign wr_stat   = wr_en & (wb_adr_i == `IPS_OFS_EVT_STAT);
  assign wr_mask   = wr_en & (wb_adr_i == `IPS_OFS_EVT_MASK);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [3:0]   pol_q;
  logic [15:0]  en_q;
  ips_pd_mode_t pd_mode_q;
  ips_pd_mode_t pd_mode_d;
  logic [5:0]   mask_q;
  logic [15:0]  pol_m;
  logic [15:0]  mask_m;

  assign pol_m  = lane_merge({12'h000, pol_q}, wdat, wb_sel_i);
  assign mask_m = lane_merge({10'h000, mask_q}, wdat, wb_sel_i);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pol_q <= `IPS_RST_POLARITY;
    end else if (wr_pol) begin
      pol_q <= pol_m[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q <= `IPS_RST_ENABLE;
    end else if (wr_en_reg) begin
      en_q <= lane_merge(en_q, wdat, wb_sel_i);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= `IPS_RST_EVT_MASK;
    end else if (wr_mask) begin
      mask_q <= mask_m[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge capture

  logic [3:0] ext_hit;
  logic       nmi_hit;

  ips_edge_det #(.W(4)) u_ext_edge (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .line     ({ext_irq_in_3, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}),
    .falling  (pol_q),
    .edge_hit (ext_hit)
  );

  ips_edge_det #(.W(1)) u_nmi_edge (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .line     (nmi_in),
    .falling  (1'b0),
    .edge_hit (nmi_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // pending slots and selection

  logic [15:0] pend_q;
  logic [15:0] pend_set;
  logic [15:0] pend_clr;
  logic [15:0] eligible;
  logic        cand_found;
  ips_slot_t   cand_slot;
  ips_state_t  state_q;
  logic        take;

  always_comb begin
    pend_set = 16'h0000;
    pend_set[`IPS_SLOT_NMI] = nmi_hit;
    pend_set[`IPS_SLOT_EXT0 +: 4] = ext_hit;
    pend_set[`IPS_SLOT_INT0 +: 8] = int_req_in;
  end

  // nonmaskable slot ignores the enables
  always_comb begin
    eligible = pend_q & en_q & {16{en_q[`IPS_EN_GLOBAL]}};
    eligible[`IPS_SLOT_NMI] = pend_q[`IPS_SLOT_NMI];
    eligible[0]             = 1'b0;
  end

  ips_prio_enc u_prio (
    .req   (eligible),
    .found (cand_found),
    .slot  (cand_slot)
  );

  assign take     = (state_q == IPS_IDLE) & cand_found;
  assign pend_clr = take ? (16'h0001 << cand_slot) : 16'h0000;

  // a new edge in the cycle its slot is taken stays pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 16'h0000;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // service sequencer

  logic [2:0] ack_cnt_q;
  logic [3:0] num_q;
  logic       ack_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q   <= IPS_IDLE;
      ack_cnt_q <= 3'd0;
    end else begin
      case (state_q)
        IPS_IDLE: begin
          if (take) begin
            state_q   <= IPS_ACK;
            ack_cnt_q <= `IPS_ACK_CYCLES - 3'd1;
          end
        end
        IPS_ACK: begin
          if (ack_cnt_q == 3'd0) begin
            state_q <= IPS_BUSY;
          end else begin
            ack_cnt_q <= ack_cnt_q - 3'd1;
          end
        end
        IPS_BUSY: begin
          if (wr_svc) begin
            state_q <= IPS_IDLE;
          end
        end
        default: begin
          state_q   <= IPS_IDLE;
          ack_cnt_q <= 3'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else if (take) begin
      ack_q <= 1'b1;
    end else if ((state_q == IPS_ACK) && (ack_cnt_q == 3'd0)) begin
      ack_q <= 1'b0;
    end
  end

  // number loads with acknowledge and holds until the next take
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      num_q <= 4'h0;
    end else if (take) begin
      num_q <= cand_slot;
    end
  end

  assign irq_ack_out         = ack_q;
  assign active_irq_number_0 = num_q[0];
  assign active_irq_number_1 = num_q[1];
  assign active_irq_number_2 = num_q[2];
  assign active_irq_number_3 = num_q[3];

  ////////////////////////////////////////////////////////////////////////
  // power-down

  // taking an interrupt wakes the device; a software write wins
  always_comb begin
    pd_mode_d = pd_mode_q;
    if (wr_pd && wb_sel_i[0]) begin
      pd_mode_d = ips_pd_mode_t'(wdat[1:0]);
    end else if (take) begin
      pd_mode_d = `IPS_RST_PWRDN;
    end
  end

  logic pd_flag_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_mode_q <= `IPS_RST_PWRDN;
      pd_flag_q <= 1'b0;
    end else begin
      pd_mode_q <= pd_mode_d;
      pd_flag_q <= pd_deep(pd_mode_d);
    end
  end

  assign powerdown_flag = pd_flag_q;

  ////////////////////////////////////////////////////////////////////////
  // event status and interrupt output

  logic [5:0]  stat_q;
  logic [5:0]  stat_set;
  logic [5:0]  stat_clr;
  logic [15:0] stat_m;
  logic        irq_q;

  assign stat_set = {take, ext_hit, nmi_hit};
  assign stat_m   = lane_merge(16'h0000, wdat, wb_sel_i);
  assign stat_clr = wr_stat ? stat_m[5:0] : 6'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_q <= 6'h00;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
      irq_q  <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
    end
  end

  assign irq_out = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge

  logic [31:0] rdat;
  logic [31:0] dat_q;
  logic        wb_ack_q;

  always_comb begin
    rdat = 32'h0000_0000;
    case (wb_adr_i)
      `IPS_OFS_POLARITY: rdat = {28'h000_0000, pol_q};
      `IPS_OFS_ENABLE:   rdat = {16'h0000, en_q};
      `IPS_OFS_PENDING:  rdat = {16'h0000, pend_q};
      `IPS_OFS_SERVICE:  rdat = {27'h000_0000, state_q != IPS_IDLE, num_q};
      `IPS_OFS_PWRDN:    rdat = {30'h0000_0000, pd_mode_q};
      `IPS_OFS_EVT_STAT: rdat = {26'h000_0000, stat_q};
      `IPS_OFS_EVT_MASK: rdat = {26'h000_0000, mask_q};
      default:           rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_q <= 1'b0;
      dat_q    <= 32'h0000_0000;
    end else begin
      wb_ack_q <= bus_req;
      if (rd_en) begin
        dat_q <= rdat;
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = dat_q;

endmodule : ips_top

// *** sim/ips_chk.sv ***
// Purpose: assertions on the ports of the interrupt pin block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to ips_top after the module
`timescale 1ns/10ps
`include "ips_map.svh"

module ips_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        nmi_in,
  input wire logic        irq_ack_out,
  input wire logic        active_irq_number_0,
  input wire logic        active_irq_number_1,
  input wire logic        active_irq_number_2,
  input wire logic        active_irq_number_3,
  input wire logic        powerdown_flag,
  input wire logic        irq_out
);
  logic [3:0] num;
  logic       wr_ok;
  logic       idle_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  assign num   = {active_irq_number_3, active_irq_number_2,
                  active_irq_number_1, active_irq_number_0};
  assign wr_ok = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  // idle from reset or end of service until the acknowledge of the next take is seen
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_q <= 1'b1;
    end else if (wr_ok && wb_adr_i == `IPS_OFS_SERVICE) begin
      idle_q <= 1'b1;
    end else if (irq_ack_out) begin
      idle_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  chk_wb_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a one-cycle answer");
  chk_ack_len: assert property (
    $rose(irq_ack_out) |=> irq_ack_out ##1 !irq_ack_out)
    else $error("acknowledge pulse length wrong");
  chk_num_hold: assert property (
    $rose(irq_ack_out) |=> $stable(num))
    else $error("number changed during acknowledge");
  chk_num_slot: assert property (
    $rose(irq_ack_out) |-> num inside {4'h1, [4'h4:4'hf]})
    else $error("number names no service slot");
  chk_nmi_take: assert property (
    $rose(nmi_in) && idle_q && !irq_ack_out
      |-> ##[2:4] (irq_ack_out && num == `IPS_SLOT_NMI))
    else $error("nonmaskable edge not taken");
  chk_pd_flag: assert property (
    wr_ok && wb_adr_i == `IPS_OFS_PWRDN
      |=> powerdown_flag == $past(wb_dat_i[1]))
    else $error("power-down flag disagrees with mode");
  chk_irq_mask: assert property (
    wr_ok && wb_adr_i == `IPS_OFS_EVT_MASK && wb_dat_i[5:0] == 6'h00
      |-> ##2 !irq_out)
    else $error("interrupt output high with all masked");
endmodule : ips_chk

bind ips_top ips_chk ips_chk_i (
  .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .nmi_in, .irq_ack_out, .active_irq_number_0,
  .active_irq_number_1, .active_irq_number_2, .active_irq_number_3,
  .powerdown_flag, .irq_out);

// *** sim/ips_src.sv ***
// Purpose: model of the external interrupt sources
// Assumes: lines change just after a rising clock edge
// Notes:   index 0..3 are the external lines, 4 the nonmaskable line
`timescale 1ns/10ps

module ips_src (
  input  wire logic clk,
  output logic      nmi_in,
  output logic      ext_irq_in_0,
  output logic      ext_irq_in_1,
  output logic      ext_irq_in_2,
  output logic      ext_irq_in_3
);
  logic [4:0] lvl_q;

  initial lvl_q = 5'h00;
  assign {nmi_in, ext_irq_in_3, ext_irq_in_2, ext_irq_in_1,
          ext_irq_in_0} = lvl_q;

  // hold sets how slowly the source makes its next move
  task automatic set_line(input int n, input logic v, input int hold);
    @(posedge clk);
    lvl_q[n] <= v;
    repeat (hold) @(posedge clk);
  endtask : set_line
endmodule : ips_src

// *** sim/test_ips_top.sv ***
// Purpose: self-checking bench of the interrupt pin signalling block
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes:   registers over classic wishbone, lines from the source model
`timescale 1ns/10ps
`include "ips_map.svh"

module test_ips_top
  import ips_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  int_req_in;
  logic        nmi_in;
  logic        ext_irq_in_0, ext_irq_in_1, ext_irq_in_2, ext_irq_in_3;
  logic        irq_ack_out;
  logic        active_irq_number_0, active_irq_number_1;
  logic        active_irq_number_2, active_irq_number_3;
  logic        powerdown_flag;
  logic        irq_out;
  ips_slot_t   num;
  logic [31:0] rd;
  logic [3:0]  sel_v = 4'hf;
  int          miscompares = 0;
  int          n_compared = 0;

  ips_src ips_src_i (.clk, .nmi_in, .ext_irq_in_0, .ext_irq_in_1,
    .ext_irq_in_2, .ext_irq_in_3);
  ips_top ips_top_i (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .nmi_in,
    .ext_irq_in_0, .ext_irq_in_1, .ext_irq_in_2, .ext_irq_in_3,
    .int_req_in, .irq_ack_out, .active_irq_number_0, .active_irq_number_1,
    .active_irq_number_2, .active_irq_number_3, .powerdown_flag, .irq_out);
  assign num = {active_irq_number_3, active_irq_number_2,
                active_irq_number_1, active_irq_number_0};

  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_v;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask : rdc

  // waits for the take, checks it, then ends the service
  task automatic take(input ips_slot_t n);
    int k;
    k = 0;
    while (irq_ack_out !== 1'b1 && k < 8) begin
      @(posedge clk);
      k++;
    end
    cmp({27'h0, irq_ack_out, num}, {27'h0, 1'b1, n});
    rdc(`IPS_OFS_SERVICE, {27'h0, 1'b1, n});
    wr(`IPS_OFS_SERVICE, 32'h1);
  endtask : take

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cmp({25'h0, irq_ack_out, num, powerdown_flag, irq_out}, 32'h0);
    wr(8'h40, 32'hffff);
    for (int i = 0; i < 17; i++) rdc(8'(i * 4), 32'h0);
  endtask : t_reset

  task automatic t_ext();
    logic [3:0] pol;
    pol = 4'ha;
    wr(`IPS_OFS_POLARITY, {28'h0, pol});
    wr(`IPS_OFS_ENABLE, 32'h00f1);
    rdc(`IPS_OFS_POLARITY, 32'ha);
    // a write on lane 1 only must leave the polarity bits alone
    sel_v = 4'h2;
    wr(`IPS_OFS_POLARITY, 32'h5);
    sel_v = 4'hf;
    rdc(`IPS_OFS_POLARITY, 32'ha);
    ips_src_i.set_line(1, 1'b1, 1);
    ips_src_i.set_line(3, 1'b1, 1);
    rdc(`IPS_OFS_PENDING, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ips_src_i.set_line(i, ~pol[i], 0);
      take(4'(`IPS_SLOT_EXT0 + i));
      rdc(`IPS_OFS_EVT_STAT, (32'h1 << (i + 1)) | 32'h20);
      wr(`IPS_OFS_EVT_STAT, 32'h3f);
      ips_src_i.set_line(i, pol[i], 2);
    end
    rdc(`IPS_OFS_PENDING, 32'h0);
    rdc(`IPS_OFS_EVT_STAT, 32'h0);
  endtask : t_ext

  task automatic t_nmi();
    wr(`IPS_OFS_ENABLE, 32'h0);
    ips_src_i.set_line(4, 1'b1, 0);
    take(`IPS_SLOT_NMI);
    ips_src_i.set_line(4, 1'b0, 1);
    wr(`IPS_OFS_ENABLE, 32'h8001);
    int_req_in <= 8'h80;
    @(posedge clk);
    int_req_in <= 8'h00;
    take(4'(`IPS_SLOT_INT0 + 7));
  endtask : t_nmi

  task automatic t_pd();
    for (int m = 0; m < 4; m++) begin
      wr(`IPS_OFS_PWRDN, 32'(m));
      @(posedge clk);
      cmp({31'h0, powerdown_flag}, {31'h0, m >= 2});
    end
    ips_src_i.set_line(4, 1'b1, 0);
    take(`IPS_SLOT_NMI);
    ips_src_i.set_line(4, 1'b0, 1);
    cmp({31'h0, powerdown_flag}, 32'h0);
  endtask : t_pd

  task automatic t_irq();
    logic [31:0] seq [4];
    seq = '{32'h21, 32'h0, 32'h21, 32'h0};
    wr(`IPS_OFS_EVT_STAT, 32'h3f);
    ips_src_i.set_line(4, 1'b1, 0);
    take(`IPS_SLOT_NMI);
    ips_src_i.set_line(4, 1'b0, 1);
    for (int j = 0; j < 4; j++) begin
      if (j < 3) begin
        wr(`IPS_OFS_EVT_MASK, seq[j]);
      end else begin
        wr(`IPS_OFS_EVT_STAT, 32'h21);
      end
      repeat (2) @(posedge clk);
      cmp({31'h0, irq_out}, {31'h0, seq[j][0]});
    end
    rdc(`IPS_OFS_EVT_STAT, 32'h0);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a few hundred cycles are expected; far longer means a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    sys_rst    = 1'b1;
    wb_cyc_i   = 1'b0;
    wb_stb_i   = 1'b0;
    wb_we_i    = 1'b0;
    wb_adr_i   = 8'h00;
    wb_sel_i   = 4'hf;
    wb_dat_i   = 32'h0;
    int_req_in = 8'h00;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_ext();
    t_nmi();
    t_pd();
    t_irq();
    stop_test();
  end
endmodule : test_ips_top
